// File: rtl/port_select_status_regs.sv
`timescale 1ns/10ps
`include "port_select_status_consts.svh"

module port_select_status_regs
	import port_select_status_pkg::*;
(
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Pins and straps from outside the clock domain.
	input  wire logic [8:0] pri_gpio,
	input  wire logic [3:0] sec_gpio,
	input  wire logic [6:0] primary_bus_address,
	input  wire logic       pixel_clk,
	// Decoded access from the serial control bus slave.
	input  wire logic       bus_req,
	input  wire logic       bus_write,
	input  wire logic [6:0] bus_dev_addr,
	input  wire logic [7:0] bus_reg_addr,
	input  wire logic [7:0] bus_wdata,
	// Answer to the serial control bus slave.
	output logic            resp_valid_r,
	output logic            resp_ack_r,
	output logic [7:0]      rd_data_r,
	output logic            wr_port0_r,
	output logic            wr_port1_r,
	output logic            rd_port1_r
);

	// ****************************************
	// State and decode
	// ****************************************
	state_t     st_r;       // Registered state.
	state_t     st_nxt;     // Next state.
	logic [6:0] sec_addr;   // Secondary bus address.
	logic       hit_pri;    // Access to the primary address.
	logic       hit_sec;    // Access to the secondary address.
	logic       acc;        // Claimed access.
	logic       sec_en;     // Secondary address enable bit.
	logic       start;      // Write to the frequency counter.
	logic       pclk_rise;  // Pixel clock rising edge.
	logic       to_port1;   // Access is routed to the secondary bank.

	// Address decode; the second address is one above the first.
	always_comb begin
		sec_addr  = 7'(st_r.addr_sync + `ADDR_STEP); // see RULE_06
		sec_en    = st_r.sel[`BIT_SECONDARY_ENABLE];
		hit_pri   = bus_req && (bus_dev_addr == st_r.addr_sync);
		hit_sec   = bus_req && sec_en && (bus_dev_addr == sec_addr) && !hit_pri; // see RULE_05
		acc       = hit_pri || hit_sec;
		start     = acc && bus_write && (bus_reg_addr == `OFS_FREQ_COUNTER); // see RULE_12
		pclk_rise = st_r.pclk_sync && !st_r.pclk_prev;
		// Selects count only on the primary address with the enable clear.
		if (hit_sec) begin
			to_port1 = 1'b1;
		end else if (sec_en) begin
			to_port1 = 1'b0; // see RULE_11
		end else begin
			to_port1 = st_r.sel[`BIT_SECONDARY_SELECT]; // see RULE_08 RULE_09 RULE_10
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		// Two flip-flop synchronisers for every foreign input.
		st_nxt.pri_meta  = pri_gpio;
		st_nxt.pri_sync  = st_r.pri_meta;
		st_nxt.sec_meta  = sec_gpio;
		st_nxt.sec_sync  = st_r.sec_meta;
		st_nxt.addr_meta = primary_bus_address;
		st_nxt.addr_sync = st_r.addr_meta;
		st_nxt.pclk_meta = pixel_clk;
		st_nxt.pclk_sync = st_r.pclk_meta;
		st_nxt.pclk_prev = st_r.pclk_sync;

		// Answer strobes last one cycle.
		st_nxt.resp_valid = bus_req;
		st_nxt.resp_ack   = acc;
		st_nxt.rd_data    = `RST_BYTE;
		st_nxt.wr_port0   = 1'b0;
		st_nxt.wr_port1   = 1'b0;
		st_nxt.rd_port1   = 1'b0;

		if (acc) begin
			// Route the access to the port banks.
			if (bus_write) begin
				if (hit_sec) begin
					st_nxt.wr_port1 = 1'b1;
				end else if (sec_en) begin
					st_nxt.wr_port0 = 1'b1; // see RULE_11
				end else begin
					st_nxt.wr_port0 = st_r.sel[`BIT_PRIMARY_SELECT]; // see RULE_10
					st_nxt.wr_port1 = st_r.sel[`BIT_SECONDARY_SELECT]; // see RULE_08
				end
			end else begin
				st_nxt.rd_port1 = to_port1;
			end
			// Register writes; reserved bits are dropped.
			if (bus_write && (bus_reg_addr == `OFS_PORT_SELECT)) begin
				st_nxt.sel = bus_wdata[2:0]; // see RULE_15
			end
			// Read data of this group; other offsets read zero here.
			if (!bus_write) begin
				case (bus_reg_addr)
					`OFS_PIN_STATUS_LOW: begin
						// Raw levels; valid only for pins in input mode. see RULE_03
						st_nxt.rd_data[7:5] = st_r.pri_sync[7:5]; // see RULE_01
						st_nxt.rd_data[3:0] = to_port1 ? st_r.sec_sync : st_r.pri_sync[3:0]; // see RULE_02
					end
					`OFS_PIN_STATUS_HIGH: begin
						st_nxt.rd_data[0] = st_r.pri_sync[8]; // see RULE_04
					end
					`OFS_PORT_SELECT: begin
						st_nxt.rd_data[2:0] = st_r.sel; // see RULE_15
					end
					`OFS_FREQ_COUNTER: begin
						st_nxt.rd_data = st_r.freq_result; // see RULE_13
					end
					default: begin
						st_nxt.rd_data = `RST_BYTE;
					end
				endcase
			end
		end

		// Frequency counter window.
		case (st_r.fstate)
			FC_IDLE: begin
				st_nxt.osc_div = 2'h0;
			end
			FC_COUNT: begin
				if (pclk_rise && (st_r.edge_cnt != `EDGE_COUNT_MAX)) begin
					st_nxt.edge_cnt = 8'(st_r.edge_cnt + 8'h01); // see RULE_14
				end
				if (st_r.osc_div == 2'(`OSC_CYCLES - 1)) begin
					st_nxt.osc_div = 2'h0;
					if (st_r.win_left == 8'h01) begin
						st_nxt.fstate      = FC_IDLE;
						st_nxt.freq_result = st_nxt.edge_cnt; // see RULE_13
					end else begin
						st_nxt.win_left = 8'(st_r.win_left - 8'h01);
					end
				end else begin
					st_nxt.osc_div = 2'(st_r.osc_div + 2'h1);
				end
			end
			default: begin
				st_nxt.fstate = FC_IDLE;
			end
		endcase
		// A write restarts the window; zero gives an empty window.
		if (start) begin
			st_nxt.win_left = bus_wdata; // see RULE_12
			st_nxt.edge_cnt = `RST_BYTE;
			st_nxt.osc_div  = 2'h0;
			if (bus_wdata == `RST_BYTE) begin
				st_nxt.fstate      = FC_IDLE;
				st_nxt.freq_result = `RST_BYTE;
			end else begin
				st_nxt.fstate = FC_COUNT;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r     <= '0;
			st_r.sel <= `RST_PORT_SELECT;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register.
	always_comb begin
		resp_valid_r = st_r.resp_valid;
		resp_ack_r   = st_r.resp_ack;
		rd_data_r    = st_r.rd_data;
		wr_port0_r   = st_r.wr_port0;
		wr_port1_r   = st_r.wr_port1;
		rd_port1_r   = st_r.rd_port1;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_rd(logic [7:0] ofs);
		acc && !bus_write && bus_reg_addr == ofs;
	endsequence

	sequence s_start_one;
		start && bus_wdata == 8'h01;
	endsequence

	a_pins_upper: assert property (s_rd(`OFS_PIN_STATUS_LOW) |=> rd_data_r[7:5] == $past(st_r.pri_sync[7:5])) // see RULE_01
		else $error("Upper pin status bits wrong.");
	a_pins_lower: assert property (s_rd(`OFS_PIN_STATUS_LOW) |=>
		rd_data_r[4:0] == ($past(to_port1) ? {1'b0, $past(st_r.sec_sync)} : {1'b0, $past(st_r.pri_sync[3:0])})) // see RULE_02
		else $error("Lower pin status bits wrong.");
	a_pin_eight: assert property (s_rd(`OFS_PIN_STATUS_HIGH) |=>
		rd_data_r == {7'h00, $past(st_r.pri_sync[8])}) // see RULE_04
		else $error("Second status register wrong.");
	a_sec_answer: assert property (bus_req && sec_en && bus_dev_addr == 7'(st_r.addr_sync + 7'h01) |=> resp_ack_r) // see RULE_05
		else $error("Secondary address not claimed.");
	a_sec_silent: assert property (bus_req && !sec_en && bus_dev_addr != st_r.addr_sync |=> !resp_ack_r) // see RULE_05
		else $error("Address claimed without a match.");
	a_sel_ignored: assert property (hit_pri && sec_en && bus_write |=> wr_port0_r && !wr_port1_r) // see RULE_11
		else $error("Selects used while enable set.");
	a_sec_write: assert property (hit_pri && !sec_en && bus_write && st_r.sel[1] |=> wr_port1_r) // see RULE_08
		else $error("Secondary select write not routed.");
	a_sec_read: assert property (hit_pri && !sec_en && !bus_write && st_r.sel[1] |=> rd_port1_r) // see RULE_10
		else $error("Read not taken from secondary bank.");
	a_window_len: assert property (s_start_one ##1 !start [*2] |=> st_r.fstate == FC_IDLE && $past(st_r.fstate) == FC_COUNT) // see RULE_12
		else $error("Window length wrong.");
	a_count_sat: assert property (st_r.fstate == FC_COUNT && st_r.edge_cnt == 8'hff && !start |=> st_r.edge_cnt == 8'hff) // see RULE_14
		else $error("Edge count wrapped.");
	a_freq_read: assert property (s_rd(`OFS_FREQ_COUNTER) |=> rd_data_r == $past(st_r.freq_result)) // see RULE_13
		else $error("Frequency read wrong.");

endmodule

// File: rtl/port_select_status_consts.svh
// Contract
// RULE_01 - Status bits 7..5 show general pins 7..5.
// RULE_02 - Bits 3..0 show primary or secondary pins.
// RULE_03 - Status bits meaningful only in input mode.
// RULE_04 - Second status register bit 0 shows pin 8.
// RULE_05 - Enable bit makes device answer second address.
// RULE_06 - Second address is primary address plus one.
// RULE_07 - Host sets enable before mirror remote access.
// RULE_08 - Secondary select writes secondary, reads secondary.
// RULE_09 - Host clears secondary select to read primary.
// RULE_10 - Primary select writes primary; both reads secondary.
// RULE_11 - Select bits ignored while enable bit set.
// RULE_12 - Write N starts N oscillator period window.
// RULE_13 - Read returns edges counted in last window.
// RULE_14 - Edge count saturates and holds at 0xff.
// RULE_15 - Reserved bits read zero, ignore writes.
`ifndef PORT_SELECT_STATUS_CONSTS_SVH
`define PORT_SELECT_STATUS_CONSTS_SVH

// ****************************************
// Register offsets and reset values
// ****************************************
`define OFS_PIN_STATUS_LOW   8'h1c
`define OFS_PIN_STATUS_HIGH  8'h1d
`define OFS_PORT_SELECT      8'h1e
`define OFS_FREQ_COUNTER     8'h1f
`define RST_PORT_SELECT      3'h1
`define RST_BYTE             8'h00

// ****************************************
// Field positions of the port select register
// ****************************************
`define BIT_PRIMARY_SELECT   0
`define BIT_SECONDARY_SELECT 1
`define BIT_SECONDARY_ENABLE 2

// ****************************************
// Timing and limit of the frequency counter, secondary address step
// ****************************************
`define CLK_PERIOD_NS        20
`define OSC_PERIOD_NS        40
`define OSC_CYCLES           (`OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define EDGE_COUNT_MAX       8'hff
`define ADDR_STEP            7'h01

`endif

// File: rtl/port_select_status_pkg.sv
`include "port_select_status_consts.svh"

package port_select_status_pkg;

	// Frequency counter phases.
	typedef enum logic [0:0] {
		FC_IDLE  = 1'b0,
		FC_COUNT = 1'b1
	} fc_state_t;

	// Whole state of the register bank.
	typedef struct packed {
		logic [8:0] pri_meta;    // First stage of primary pin synchroniser.
		logic [8:0] pri_sync;    // Synchronised primary pin levels.
		logic [3:0] sec_meta;    // First stage of secondary pin synchroniser.
		logic [3:0] sec_sync;    // Synchronised secondary pin levels.
		logic [6:0] addr_meta;   // First stage of bus address strap sync.
		logic [6:0] addr_sync;   // Synchronised primary bus address.
		logic       pclk_meta;   // First stage of pixel clock sync.
		logic       pclk_sync;   // Synchronised pixel clock.
		logic       pclk_prev;   // Previous pixel clock level.
		logic [2:0] sel;         // Port access select bits.
		fc_state_t  fstate;      // Frequency counter phase.
		logic [7:0] win_left;    // Oscillator periods left in window.
		logic [1:0] osc_div;     // Core cycles within one oscillator period.
		logic [7:0] edge_cnt;    // Edges seen in the running window.
		logic [7:0] freq_result; // Edges seen in the last finished window.
		logic       resp_valid;  // Answer strobe.
		logic       resp_ack;    // Address was claimed.
		logic [7:0] rd_data;     // Read data.
		logic       wr_port0;    // Write reaches primary port bank.
		logic       wr_port1;    // Write reaches secondary port bank.
		logic       rd_port1;    // Read comes from secondary port bank.
	} state_t;

endpackage

// File: sim/bus_host_model.sv
`timescale 1ns/10ps
// ****************************************
// Host side of the decoded control bus
// ****************************************
module bus_host_model
	import port_select_status_pkg::*;
(
	// Clock.
	input  wire logic       core_clk,
	// Request towards the bank.
	output logic            bus_req,
	output logic            bus_write,
	output logic [6:0]      bus_dev_addr,
	output logic [7:0]      bus_reg_addr,
	output logic [7:0]      bus_wdata,
	// Answer from the bank.
	input  wire logic       resp_valid_r,
	input  wire logic       resp_ack_r,
	input  wire logic [7:0] rd_data_r,
	input  wire logic       wr_port0_r,
	input  wire logic       wr_port1_r,
	input  wire logic       rd_port1_r
);
	logic [7:0] got_data; // Captured answer fields.
	logic [4:0] got_flags;

	// Idle bus at time zero.
	initial begin
		bus_req      = 1'b0;
		bus_write    = 1'b0;
		bus_dev_addr = 7'h00;
		bus_reg_addr = 8'h00;
		bus_wdata    = 8'h00;
	end

	// One access: a single request pulse; the answer stands for one cycle only, so it is captured at the
	// falling edge right after the rising edge that took the request, and only then is the request dropped.
	task automatic access(input logic [6:0] dev, input logic wr, input logic [7:0] ofs, input logic [7:0] wd);
		@(negedge core_clk);
		bus_req      = 1'b1;
		bus_write    = wr;
		bus_dev_addr = dev;
		bus_reg_addr = ofs;
		bus_wdata    = wd;
		@(negedge core_clk);
		got_data     = rd_data_r;
		got_flags    = {resp_valid_r, resp_ack_r, wr_port0_r, wr_port1_r, rd_port1_r};
		bus_req      = 1'b0;
		bus_wdata    = ~wd; // Stale data is not left on the lines.
	endtask
endmodule

// File: sim/port_select_status_regs_tb.sv
`timescale 1ns/10ps
module port_select_status_regs_tb
	import port_select_status_pkg::*;
;
	logic [6:0] adr; // Strapped address; the values used are arbitrary.
	logic       core_clk, rst_n, bus_req, bus_write, resp_valid_r, resp_ack_r;
	logic       wr_port0_r, wr_port1_r, rd_port1_r;
	logic       pixel_clk = 1'b0; // Pixel clock of the far side.
	logic [8:0] pri_gpio;
	logic [3:0] sec_gpio;
	logic [3:0] pix_cnt  = 4'h0; // Falling edges since the last pixel clock toggle.
	logic [3:0] pix_half = 4'h4; // Falling edges per pixel half period, less one.
	logic [6:0] bus_dev_addr;
	logic [7:0] bus_reg_addr, bus_wdata, rd_data_r;
	int         n_fail, samples_checked;

	port_select_status_regs uut (.core_clk(core_clk), .rst_n(rst_n), .pri_gpio(pri_gpio), .sec_gpio(sec_gpio),
		.primary_bus_address(adr), .pixel_clk(pixel_clk), .bus_req(bus_req), .bus_write(bus_write),
		.bus_dev_addr(bus_dev_addr), .bus_reg_addr(bus_reg_addr), .bus_wdata(bus_wdata),
		.resp_valid_r(resp_valid_r), .resp_ack_r(resp_ack_r), .rd_data_r(rd_data_r),
		.wr_port0_r(wr_port0_r), .wr_port1_r(wr_port1_r), .rd_port1_r(rd_port1_r));
	bus_host_model host (.core_clk(core_clk), .bus_req(bus_req), .bus_write(bus_write),
		.bus_dev_addr(bus_dev_addr), .bus_reg_addr(bus_reg_addr), .bus_wdata(bus_wdata),
		.resp_valid_r(resp_valid_r), .resp_ack_r(resp_ack_r), .rd_data_r(rd_data_r),
		.wr_port0_r(wr_port0_r), .wr_port1_r(wr_port1_r), .rd_port1_r(rd_port1_r));

	// 50 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Pixel clock of ten core periods by default, two at the fastest, launched at the falling edge.
	always @(negedge core_clk) begin
		pix_cnt   <= (pix_cnt >= pix_half) ? 4'h0 : pix_cnt + 4'h1;
		pixel_clk <= (pix_cnt >= pix_half) ? ~pixel_clk : pixel_clk;
	end

	// Compares a value and counts it.
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Compares a count against an inclusive range from lo to hi.
	task automatic chk_range(input string what, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
		samples_checked++;
		if (!(got >= lo && got <= hi) || $isunknown(got)) begin
			n_fail++;
			$display("[FAIL] %s expected %h to %h seen %h", what, lo, hi, got);
		end
	endtask

	// Access with expected data and flags {valid, ack, port0 write, port1 write, port1 read}.
	task automatic acc(input logic [6:0] d, input logic w, input logic [7:0] o, input logic [7:0] v,
		input logic [7:0] ed, input logic [4:0] ef);
		host.access(d, w, o, v);
		chk("read data", ed, host.got_data);
		chk("answer flags", {3'h0, ef}, {3'h0, host.got_flags});
	endtask

	// Verdict.
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Watchdog.
	initial begin
		#200us;
		n_fail++;
		summarize();
	end

	// Main sequence.
	initial begin
		n_fail = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		adr = 7'h2c;
		pri_gpio = 9'h1ea;
		sec_gpio = 4'h5;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk) rst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		acc(adr, 0, 8'h1e, 8'h00, 8'h01, 5'h18);
		acc(adr, 0, 8'h1f, 8'h00, 8'h00, 5'h18);
		acc(adr, 0, 8'h1c, 8'h00, 8'hea, 5'h18);
		acc(adr, 0, 8'h1d, 8'h00, 8'h01, 5'h18);
		acc(adr, 1, 8'h1c, 8'hff, 8'h00, 5'h1c);
		acc(adr, 0, 8'h1c, 8'h00, 8'hea, 5'h18);
		acc(adr, 0, 8'h10, 8'h00, 8'h00, 5'h18);
		acc(adr + 7'h01, 0, 8'h1e, 8'h00, 8'h00, 5'h10);
		acc(adr, 1, 8'h1e, 8'hfa, 8'h00, 5'h1c);
		acc(adr, 0, 8'h1e, 8'h00, 8'h02, 5'h19);
		acc(adr, 0, 8'h1c, 8'h00, 8'he5, 5'h19);
		acc(adr, 1, 8'h10, 8'h33, 8'h00, 5'h1a);
		acc(adr, 1, 8'h1e, 8'h03, 8'h00, 5'h1a);
		acc(adr, 1, 8'h10, 8'h33, 8'h00, 5'h1e);
		acc(adr, 0, 8'h1c, 8'h00, 8'he5, 5'h19);
		acc(adr, 1, 8'h1e, 8'h07, 8'h00, 5'h1e);
		acc(adr + 7'h01, 0, 8'h1e, 8'h00, 8'h07, 5'h19);
		acc(adr + 7'h01, 1, 8'h10, 8'h33, 8'h00, 5'h1a);
		acc(adr, 1, 8'h10, 8'h33, 8'h00, 5'h1c);
		acc(adr, 0, 8'h1c, 8'h00, 8'hea, 5'h18);
		acc(adr, 1, 8'h1e, 8'h01, 8'h00, 5'h1c);
		acc(adr, 1, 8'h1f, 8'd50, 8'h00, 5'h1c);
		acc(adr, 0, 8'h1f, 8'h00, 8'h00, 5'h18);
		repeat (100) @(posedge core_clk);
		host.access(adr, 0, 8'h1f, 8'h00);
		chk_range("edge count", 8'd9, 8'd11, host.got_data);
		acc(adr, 1, 8'h1f, 8'd20, 8'h00, 5'h1c);
		repeat (40) @(posedge core_clk);
		host.access(adr, 0, 8'h1f, 8'h00);
		chk_range("second count", 8'd3, 8'd5, host.got_data);
		// Shortest window of one oscillator period, read once it has closed.
		acc(adr, 1, 8'h1f, 8'h01, 8'h00, 5'h1c);
		acc(adr, 0, 8'h1e, 8'h00, 8'h01, 5'h18);
		host.access(adr, 0, 8'h1f, 8'h00);
		chk_range("short count", 8'd0, 8'd1, host.got_data);
		// Fastest pixel clock over the longest window fills the count to its top.
		pix_half = 4'h0;
		repeat (4) @(posedge core_clk);
		acc(adr, 1, 8'h1f, 8'hff, 8'h00, 5'h1c);
		repeat (520) @(posedge core_clk);
		host.access(adr, 0, 8'h1f, 8'h00);
		chk("full count", 8'hff, host.got_data);
		acc(adr, 1, 8'h1f, 8'h00, 8'h00, 5'h1c);
		acc(adr, 0, 8'h1f, 8'h00, 8'h00, 5'h18);
		// A new strapped address is followed; the old one is no longer claimed.
		@(negedge core_clk) adr = 7'h15;
		repeat (3) @(posedge core_clk);
		acc(7'h15, 0, 8'h1e, 8'h00, 8'h01, 5'h18);
		acc(7'h2c, 0, 8'h1e, 8'h00, 8'h00, 5'h10);
		summarize();
	end
endmodule
